// ### design/fws_flash_ctrl.sv
// Function
// R1 - program busy: bit 7 inverts written data
// R2 - full bus valid 1 us after finish
// R3 - erase busy reads 0, then 1
// R4 - polling valid from 4th/6th strobe
// R5 - polling needs valid address
// R6 - bit 6 alternates while busy
// R7 - alternating bit valid from 4th/6th strobe
// R8 - strobe pulses under 5 ns filtered
// R9 - gate low, strobe high blocks writes
// R10 - program needs three-byte unlock
// R11 - erase needs six-byte sequence
// R12 - command guard always on
// R13 - bad command returns to read
// R14 - identification mode returns maker, part codes
// R15 - host holds reset high during erase
// R16 - host holds main protect high
// R17 - host holds top protect high too
// R18 - drive data only while gate low
// R19 - latch muxed address and data
// R20 - select pin chooses parallel mode
// R21 - row on fall, column on rise
// R22 - erase codes 30h, 50h, 10h
// R23 - commands ignored while busy
// R24 - host re-reads twice on doubt
// R25 - alternating bit flips per read
// R26 - idle reads return stored data
`timescale 1ns/100ps
module fws_flash_ctrl
  import fws_pkg::*;
#(
  parameter int ERASE_CYC = ERASE_CYC_DEF
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic interface_select,
  input wire logic [fws_pkg::ADDR_PINS-1:0] muxed_address_lines,
  input wire logic row_col_sel,
  input wire logic write_strobe_n,
  input wire logic output_gate_n,
  input wire logic main_area_protect_n,
  input wire logic top_area_protect_n,
  input wire logic [fws_pkg::DATA_W-1:0] data_in,
  output logic [fws_pkg::DATA_W-1:0] data_out,
  output logic data_oe_n,
  output logic busy
);
  import fws_pkg::*;

  typedef enum {ST_IDLE, ST_U1, ST_U2, ST_PROG, ST_E1, ST_E2, ST_E3} fws_seq_t;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  fws_op_if op_if ();
  logic we_n_f;
  logic we_prev_q;
  logic oe_prev_q, oe_prev_d;
  logic rc_prev_q;
  logic [ADDR_PINS-1:0] row_q, row_d;
  logic [ADDR_PINS-1:0] col_q, col_d;
  logic [DATA_W-1:0] mem [ARRAY_DEPTH];
  fws_seq_t seq_q, seq_d;
  logic id_mode_q, id_mode_d;
  logic erase_q, erase_d;
  logic [DATA_W-1:0] wdata_q, wdata_d;
  logic [ARRAY_AW-1:0] waddr_q, waddr_d;
  fws_op_t wop_q, wop_d;
  logic toggle_q, toggle_d;
  logic [CNT_W-1:0] settle_q, settle_d;
  logic [DATA_W-1:0] dout_q, dout_d;
  logic start;
  logic we_rise;
  logic pp_en;
  logic [ADDR_W-1:0] full_addr;

  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [15:0] v);
    addr_is = (a[15:0] == v);
  endfunction : addr_is

  // ---------------------------------------------------------------
  // strobe filter and timer
  // ---------------------------------------------------------------
  fws_strobe_filter u_filt (
    .clk(clk),
    .rst_b(rst_b),
    .raw_n(write_strobe_n),
    .clean_n(we_n_f)
  );

  fws_op_timer #(.ERASE_CYC(ERASE_CYC)) u_tmr (
    .clk(clk),
    .rst_b(rst_b),
    .op_if(op_if)
  );

  // ---------------------------------------------------------------
  // address latching and edge detect
  // ---------------------------------------------------------------
  assign pp_en = interface_select; // [R20]
  assign full_addr = {col_q, row_q}; // [R19]
  assign we_rise = !we_prev_q && we_n_f && output_gate_n; // [R9] [R21]
  assign busy = op_if.busy;

  always_comb
  begin
    row_d = row_q;
    col_d = col_q;
    if (rc_prev_q && !row_col_sel)
      row_d = muxed_address_lines; // [R21]
    if (!rc_prev_q && row_col_sel)
      col_d = muxed_address_lines; // [R21]
  end

  // ---------------------------------------------------------------
  // command sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    seq_d = seq_q;
    id_mode_d = id_mode_q;
    erase_d = erase_q;
    wdata_d = wdata_q;
    waddr_d = waddr_q;
    wop_d = wop_q;
    start = 1'b0;
    if (we_rise && pp_en && !op_if.busy) // [R23]
    begin
      seq_d = ST_IDLE; // [R13]
      unique case (seq_q)
        ST_IDLE:
        begin
          if (data_in == CMD_ID_EXIT)
            id_mode_d = 1'b0;
          else if (addr_is(full_addr, UNLOCK_ADDR1) && data_in == UNLOCK_DATA1)
            seq_d = ST_U1;
        end
        ST_U1:
          if (addr_is(full_addr, UNLOCK_ADDR2) && data_in == UNLOCK_DATA2)
            seq_d = ST_U2;
        ST_U2:
        begin
          if (addr_is(full_addr, UNLOCK_ADDR1))
          begin
            if (data_in == CMD_PROGRAM)
              seq_d = erase_q ? ST_IDLE : ST_PROG; // [R10] [R12]
            else if (data_in == CMD_ERASE_SETUP && !erase_q)
              seq_d = ST_E1;
            else if (data_in == CMD_ID_ENTRY && !erase_q)
              id_mode_d = 1'b1; // [R14]
          end
          if (erase_q)
          begin
            erase_d = 1'b0;
            wop_d = FWS_OP_SECT;
            if (data_in == CMD_SECTOR_ERASE)
              start = 1'b1; // [R11] [R22]
            else if (data_in == CMD_BLOCK_ERASE)
              begin
                wop_d = FWS_OP_BLOCK;
                start = 1'b1; // [R22]
              end
            else if (data_in == CMD_CHIP_ERASE && addr_is(full_addr, UNLOCK_ADDR1))
              begin
                wop_d = FWS_OP_CHIP;
                start = 1'b1; // [R22]
              end
          end
        end
        ST_PROG:
        begin
          wop_d = FWS_OP_PROG;
          wdata_d = data_in; // [R19]
          start = 1'b1; // [R10]
        end
        ST_E1:
          if (addr_is(full_addr, UNLOCK_ADDR1) && data_in == UNLOCK_DATA1)
            seq_d = ST_E2;
        ST_E2:
          if (addr_is(full_addr, UNLOCK_ADDR2) && data_in == UNLOCK_DATA2)
          begin
            seq_d = ST_U2;
            erase_d = 1'b1; // [R11]
          end
        ST_E3:
          seq_d = ST_IDLE;
      endcase
      if (seq_d == ST_IDLE)
        erase_d = erase_d && (seq_q == ST_E2);
      if (start)
      begin
        waddr_d = full_addr[ARRAY_AW-1:0];
        // protect pins gate the start; holding them is the host's duty [R16] [R17]
        if (!main_area_protect_n && !full_addr[ADDR_W-1])
          start = 1'b0;
        if (!top_area_protect_n && full_addr[ADDR_W-1])
          start = 1'b0;
        if ((wop_d == FWS_OP_CHIP) && (!main_area_protect_n || !top_area_protect_n))
          start = 1'b0;
      end
    end
  end
  assign op_if.start = start;
  assign op_if.op = wop_d;

  // ---------------------------------------------------------------
  // status and read data
  // ---------------------------------------------------------------
  always_comb
  begin
    oe_prev_d = output_gate_n;
    toggle_d = toggle_q;
    settle_d = settle_q;
    dout_d = dout_q;
    if (op_if.done)
      settle_d = CNT_W'(SETTLE_CYC); // [R2]
    else if (settle_q != '0)
      settle_d = settle_q - CNT_W'(1);
    if (op_if.busy && output_gate_n && !oe_prev_q)
      toggle_d = !toggle_q; // [R6] [R25]
    if (!output_gate_n)
    begin
      // the array is written on the done cycle, so status still stands then
      if (op_if.busy || op_if.done)
      begin
        dout_d = {DATA_W{1'b0}};
        dout_d[6] = toggle_q; // [R6] [R7]
        if (wop_q == FWS_OP_PROG)
          dout_d[7] = !wdata_q[7]; // [R1] [R4] [R5]
        else
          dout_d[7] = 1'b0; // [R3] [R4]
      end
      else if (id_mode_q && full_addr == MAKER_CODE_OFS)
        dout_d = MAKER_CODE_VAL; // [R14]
      else if (id_mode_q && full_addr == PART_CODE_OFS)
        dout_d = PART_CODE_VAL; // [R14]
      else
      begin
        dout_d = mem[full_addr[ARRAY_AW-1:0]]; // [R26]
        if (settle_q != '0)
          dout_d[6:0] = {(DATA_W-1){1'b0}}; // [R2]
      end
    end
  end

  // ---------------------------------------------------------------
  // array update; reset aborts an erase, hence the host duty [R15]
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (op_if.done)
    begin
      if (wop_q == FWS_OP_PROG)
        mem[waddr_q] <= mem[waddr_q] & wdata_q;
      else
        for (int i = 0; i < ARRAY_DEPTH; i++)
          mem[i] <= ERASED_BYTE;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      we_prev_q <= 1'b1;
      oe_prev_q <= 1'b1;
      rc_prev_q <= 1'b1;
      row_q <= '0;
      col_q <= '0;
      seq_q <= ST_IDLE;
      id_mode_q <= 1'b0;
      erase_q <= 1'b0;
      wdata_q <= '0;
      waddr_q <= '0;
      wop_q <= FWS_OP_PROG;
      toggle_q <= 1'b0;
      settle_q <= '0;
      dout_q <= '0;
    end
    else
    begin
      we_prev_q <= we_n_f;
      oe_prev_q <= oe_prev_d;
      rc_prev_q <= row_col_sel;
      row_q <= row_d;
      col_q <= col_d;
      seq_q <= seq_d;
      id_mode_q <= id_mode_d;
      erase_q <= erase_d;
      wdata_q <= wdata_d;
      waddr_q <= waddr_d;
      if (start)
        wop_q <= wop_d;
      toggle_q <= toggle_d;
      settle_q <= settle_d;
      dout_q <= dout_d;
    end
  end

  assign data_out = dout_q;
  assign data_oe_n = output_gate_n || !pp_en; // [R18]
endmodule : fws_flash_ctrl

// ### design/fws_pkg.sv
package fws_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int ADDR_PINS = 11;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 8;
  localparam int ARRAY_DEPTH = 64;
  localparam int ARRAY_AW = 6;

  // ---------------------------------------------------------------
  // identification, values arbitrary
  // ---------------------------------------------------------------
  localparam logic [7:0] MAKER_CODE_VAL = 8'ha5;
  localparam logic [7:0] PART_CODE_VAL = 8'h3c;
  localparam logic [ADDR_W-1:0] MAKER_CODE_OFS = 22'h000000;
  localparam logic [ADDR_W-1:0] PART_CODE_OFS = 22'h000001;
  localparam logic [31:0] ID_SYS_BASE = 32'hffbc0000;

  // ---------------------------------------------------------------
  // command sequence addresses and codes
  // ---------------------------------------------------------------
  localparam logic [15:0] UNLOCK_ADDR1 = 16'h5555;
  localparam logic [15:0] UNLOCK_ADDR2 = 16'h2aaa;
  localparam logic [7:0] UNLOCK_DATA1 = 8'haa;
  localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'h50;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
  localparam logic [7:0] CMD_ID_EXIT = 8'hf0;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // ---------------------------------------------------------------
  // timing at 20 MHz
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int GLITCH_NS = 5;
  localparam int GLITCH_CYC = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYC = SETTLE_NS / CLK_PERIOD_NS;
  localparam int PROG_NS = 20000;
  localparam int PROG_CYC = PROG_NS / CLK_PERIOD_NS;
  localparam int ERASE_CYC_DEF = 360000;
  localparam int CNT_W = 20;

  typedef enum logic [1:0] {FWS_OP_PROG, FWS_OP_SECT, FWS_OP_BLOCK, FWS_OP_CHIP} fws_op_t;
endpackage : fws_pkg

// ### design/fws_op_if.sv
`timescale 1ns/100ps
interface fws_op_if;
  import fws_pkg::*;
  logic start;
  fws_op_t op;
  logic busy;
  logic done;
  modport req (output start, output op, input busy, input done);
  modport tmr (input start, input op, output busy, output done);
endinterface : fws_op_if

// ### design/fws_strobe_filter.sv
`timescale 1ns/100ps
module fws_strobe_filter
  import fws_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic raw_n,
  output logic clean_n
);
  logic clean_q, clean_d;
  logic [3:0] cnt_q, cnt_d;

  // ---------------------------------------------------------------
  // glitch filter: level must persist before it is accepted
  // ---------------------------------------------------------------
  always_comb
  begin
    clean_d = clean_q;
    cnt_d = 4'h0;
    if (raw_n != clean_q)
    begin
      cnt_d = cnt_q + 4'h1;
      if (int'(cnt_q) >= GLITCH_CYC) // [R8]
      begin
        clean_d = raw_n;
        cnt_d = 4'h0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      clean_q <= 1'b1;
      cnt_q <= 4'h0;
    end
    else
    begin
      clean_q <= clean_d;
      cnt_q <= cnt_d;
    end
  end

  assign clean_n = clean_q;
endmodule : fws_strobe_filter

// ### design/fws_op_timer.sv
`timescale 1ns/100ps
module fws_op_timer
  import fws_pkg::*;
#(
  parameter int ERASE_CYC = ERASE_CYC_DEF
)
(
  input wire logic clk,
  input wire logic rst_b,
  fws_op_if.tmr op_if
);
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic busy_q, busy_d;
  logic done_q, done_d;

  // ---------------------------------------------------------------
  // internal operation duration
  // ---------------------------------------------------------------
  always_comb
  begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (!busy_q && op_if.start)
    begin
      busy_d = 1'b1;
      cnt_d = (op_if.op == FWS_OP_PROG) ? CNT_W'(PROG_CYC) : CNT_W'(ERASE_CYC);
    end
    else if (busy_q)
    begin
      if (cnt_q <= CNT_W'(1))
      begin
        busy_d = 1'b0;
        done_d = 1'b1;
        cnt_d = '0;
      end
      else
        cnt_d = cnt_q - CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign op_if.busy = busy_q;
  assign op_if.done = done_q;
endmodule : fws_op_timer

// ### tb/fws_chk_sva.sv
`timescale 1ns/100ps
module fws_chk
  import fws_pkg::*;
#(
  parameter int ERASE_CYC = ERASE_CYC_DEF
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic interface_select,
  input wire logic write_strobe_n,
  input wire logic output_gate_n,
  input wire logic main_area_protect_n,
  input wire logic top_area_protect_n,
  input wire logic [fws_pkg::DATA_W-1:0] data_out,
  input wire logic data_oe_n,
  input wire logic busy
);
  // ---
  // helper counters
  // ---
  logic [19:0] cnt_q, cnt_d;
  logic [3:0] low_q, low_d, wid_q, wid_d, hi_q, hi_d;
  logic gate_q, tog_q, tog_d, have_q, have_d, rd_end;
  always_comb
  begin
    rd_end = output_gate_n && !gate_q;
    cnt_d = busy ? cnt_q + 20'h1 : 20'h0;
    low_d = write_strobe_n ? 4'h0 : low_q + {3'h0, low_q != 4'hf};
    hi_d = !write_strobe_n ? 4'h0 : hi_q + {3'h0, hi_q != 4'hf};
    wid_d = (write_strobe_n && low_q != 4'h0) ? low_q : wid_q;
    have_d = busy && (have_q || rd_end);
    tog_d = rd_end ? data_out[6] : tog_q;
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      {cnt_q, low_q, wid_q, hi_q, tog_q, have_q} <= '0;
      gate_q <= 1'b1;
    end
    else
    begin
      {cnt_q, low_q, wid_q, hi_q, tog_q, have_q} <= {cnt_d, low_d, wid_d, hi_d, tog_d, have_d};
      gate_q <= output_gate_n;
    end
  end
  // ---
  // properties
  // ---
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_start;
    $rose(busy);
  endsequence
  sequence s_rd_end;
    busy && have_q && rd_end;
  endsequence
  a_oe_follow: assert property (data_oe_n == !(interface_select && !output_gate_n))
    else $error("data enable wrong");
  a_busy_span: assert property ($fell(busy) |-> cnt_q == PROG_CYC || cnt_q == ERASE_CYC)
    else $error("busy length wrong");
  a_busy_min: assert property (s_start |-> busy [*8])
    else $error("busy too short");
  a_start_cause: assert property (s_start |-> wid_q >= 4'h2 && hi_q <= 4'hc)
    else $error("start without strobe");
  a_hub_idle: assert property (s_start |-> interface_select)
    else $error("start in hub mode");
  a_write_inhibit: assert property (s_start |-> $past(output_gate_n))
    else $error("start with gate low");
  a_protect_start: assert property (s_start |-> main_area_protect_n || top_area_protect_n)
    else $error("start while protected");
  a_toggle_flip: assert property (s_rd_end |-> data_out[6] != tog_q)
    else $error("status bit did not flip");
endmodule : fws_chk

bind fws_flash_ctrl fws_chk #(.ERASE_CYC(ERASE_CYC)) u_chk (
  .clk(clk), .rst_b(rst_b), .interface_select(interface_select),
  .write_strobe_n(write_strobe_n), .output_gate_n(output_gate_n),
  .main_area_protect_n(main_area_protect_n), .top_area_protect_n(top_area_protect_n),
  .data_out(data_out), .data_oe_n(data_oe_n), .busy(busy));

// ### tb/fws_host.sv
`timescale 1ns/100ps
module fws_host
  import fws_pkg::*;
(
  input wire logic clk,
  input wire logic [fws_pkg::DATA_W-1:0] data_out,
  output logic [fws_pkg::ADDR_PINS-1:0] muxed_address_lines,
  output logic row_col_sel,
  output logic write_strobe_n,
  output logic output_gate_n,
  output logic [fws_pkg::DATA_W-1:0] data_in
);
  // ---
  // parallel bus cycles
  // ---
  int low_cyc = 3;
  logic gate_hold = 1'b0;
  initial
  begin
    muxed_address_lines = '0;
    {row_col_sel, write_strobe_n, output_gate_n} = 3'h7;
    data_in = '0;
  end
  task automatic put_addr(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    muxed_address_lines <= a[10:0];
    row_col_sel <= 1'b0;
    repeat (2) @(posedge clk);
    muxed_address_lines <= a[21:11];
    row_col_sel <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : put_addr
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    put_addr(a);
    data_in <= d;
    output_gate_n <= !gate_hold;
    write_strobe_n <= 1'b0;
    repeat (low_cyc) @(posedge clk);
    write_strobe_n <= 1'b1;
    repeat (5) @(posedge clk);
    output_gate_n <= 1'b1;
    data_in <= ~d;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    put_addr(a);
    output_gate_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1 d = data_out;
    @(posedge clk);
    output_gate_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : rd
endmodule : fws_host

// ### tb/test_fws_flash_ctrl.sv
`timescale 1ns/100ps
module test_fws_flash_ctrl;
  import fws_pkg::*;
  // ---
  // bench
  // ---
  localparam logic [21:0] A1 = {6'h00, UNLOCK_ADDR1};
  localparam logic [21:0] A2 = {6'h00, UNLOCK_ADDR2};
  localparam logic [21:0] PA = 22'h000012;
  localparam logic [21:0] PB = 22'h000021;
  localparam logic [21:0] PT = 22'h200012;
  localparam logic [7:0] PD = 8'hc3;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic interface_select = 1'b1;
  logic main_area_protect_n = 1'b1;
  logic top_area_protect_n = 1'b1;
  logic [10:0] mal;
  logic rcs, wsn, ogn, data_oe_n, busy;
  logic [7:0] din, dout;
  int num_errors = 0;
  int checks_done = 0;
  always #25 clk = ~clk;
  fws_flash_ctrl #(.ERASE_CYC(50)) dut (.clk(clk), .rst_b(rst_b),
    .interface_select(interface_select), .muxed_address_lines(mal), .row_col_sel(rcs),
    .write_strobe_n(wsn), .output_gate_n(ogn), .main_area_protect_n(main_area_protect_n),
    .top_area_protect_n(top_area_protect_n), .data_in(din), .data_out(dout),
    .data_oe_n(data_oe_n),
    .busy(busy));
  fws_host host (.clk(clk), .data_out(dout), .muxed_address_lines(mal), .row_col_sel(rcs),
    .write_strobe_n(wsn), .output_gate_n(ogn), .data_in(din));
  task automatic end_of_test;
    if (num_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask : chk_bit
  task automatic wait_idle;
    for (int n = 0; busy !== 1'b0; n++)
    begin
      @(posedge clk);
      if (n > 1000)
      begin
        chk_bit(busy, 1'b0);
        end_of_test();
      end
    end
  endtask : wait_idle
  task automatic do_reset(input logic sel);
    @(posedge clk);
    rst_b <= 1'b0;
    interface_select <= sel;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset
  task automatic unlock;
    host.wr(A1, UNLOCK_DATA1);
    host.wr(A2, UNLOCK_DATA2);
  endtask : unlock
  // ---
  // scenarios
  // ---
  task automatic t_erase(input logic [7:0] code, input logic [21:0] a);
    logic [7:0] r;
    unlock();
    host.wr(A1, CMD_ERASE_SETUP);
    unlock();
    host.wr(a, code);
    host.rd(PA, r);
    chk_bit(r[7], 1'b0);
    wait_idle();
    repeat (20) @(posedge clk);
    host.rd(PA, r);
    chk_byte(r, ERASED_BYTE);
  endtask : t_erase
  task automatic t_program;
    logic [7:0] r, r2;
    unlock();
    host.wr(A1, CMD_PROGRAM);
    host.wr(PA, PD);
    host.rd(PA, r);
    chk_bit(r[7], ~PD[7]);
    host.rd(PB, r2);
    chk_bit(r2[6], ~r[6]);
    unlock();
    host.wr(A1, CMD_PROGRAM);
    host.wr(PB, 8'h00);
    wait_idle();
    host.rd(PA, r);
    chk_byte(r, {PD[7], 7'h00});
    repeat (20) @(posedge clk);
    host.rd(PA, r);
    chk_byte(r, PD);
    host.rd(PA, r);
    chk_byte(r, PD);
    host.rd(PB, r);
    chk_byte(r, ERASED_BYTE);
  endtask : t_program
  task automatic t_ident;
    logic [7:0] r;
    unlock();
    host.wr(A1, CMD_ID_ENTRY);
    host.rd(MAKER_CODE_OFS, r);
    chk_byte(r, MAKER_CODE_VAL);
    host.rd(PART_CODE_OFS, r);
    chk_byte(r, PART_CODE_VAL);
    host.wr(A1, CMD_ID_EXIT);
  endtask : t_ident
  task automatic t_guard;
    logic [7:0] r;
    for (int k = 0; k < 7; k++)
    begin
      if (k == 5)
        do_reset(1'b0);
      @(posedge clk);
      main_area_protect_n <= (k != 3);
      top_area_protect_n <= (k != 6);
      host.gate_hold = (k == 2);
      host.low_cyc = (k == 4) ? 1 : 3;
      if (k != 0)
        host.wr(A1, UNLOCK_DATA1);
      host.wr(A2, (k == 1) ? 8'h33 : UNLOCK_DATA2);
      host.wr(A1, CMD_PROGRAM);
      host.wr((k == 6) ? PT : PA, 8'h00);
      repeat (3) @(posedge clk);
      chk_bit(busy, 1'b0);
    end
    host.gate_hold = 1'b0;
    host.low_cyc = 3;
    main_area_protect_n <= 1'b1;
    top_area_protect_n <= 1'b1;
    do_reset(1'b1);
    host.rd(PA, r);
    chk_byte(r, ERASED_BYTE);
  endtask : t_guard
  initial
  begin
    do_reset(1'b1);
    t_erase(CMD_CHIP_ERASE, A1);
    t_ident();
    t_guard();
    t_program();
    t_erase(CMD_SECTOR_ERASE, PA);
    t_program();
    t_erase(CMD_BLOCK_ERASE, PA);
    end_of_test();
  end
endmodule : test_fws_flash_ctrl
